// file: verilog/dpr_pkg.sv
// constants, types and helpers shared by the process regulator modules
// assumes a 10 MHz mclk and percent values in 0.01 % steps
package dpr_pkg;

	// clock and control sample timing
	localparam int CLK_HZ         = 10_000_000;
	localparam int SAMPLE_TIME_US = 1000;
	localparam int SAMPLE_CYCLES  = (CLK_HZ / 1_000_000) * SAMPLE_TIME_US;
	localparam int SAMPLES_PER_S  = 1_000_000 / SAMPLE_TIME_US;

	// data widths
	localparam int PCT_W  = 16;
	localparam int SPD_W  = 16;
	localparam int GAIN_W = 14;
	localparam int FILT_W = 10;
	localparam int SEL_W  = 4;
	localparam int DEN_W  = 14;
	localparam int CNT_W  = 16;

	// percent scale: 100.00 % and one key step
	localparam logic [PCT_W-1:0] PCT_FULL = 16'h2710;
	localparam logic [PCT_W-1:0] PCT_STEP = 16'h0001;

	// selection codes
	localparam logic [1:0]       SFS_PID      = 2'h1;
	localparam logic [4:0]       MIF_MAN_AUTO = 5'h0f;
	localparam logic [SEL_W-1:0] REF_KEYPAD   = 4'h0;
	localparam logic [SEL_W-1:0] REF_AI2      = 4'h2;
	localparam logic [SEL_W-1:0] REF_BAD_ONE  = 4'h1;
	localparam logic [SEL_W-1:0] REF_BAD_LO   = 4'h4;
	localparam logic [SEL_W-1:0] REF_BAD_HI   = 4'h8;
	localparam logic [SEL_W-1:0] AO_PV        = 4'h6;
	localparam logic [SEL_W-1:0] AO_SP        = 4'h9;
	localparam logic [SEL_W-1:0] DISP_PV      = 4'h6;
	localparam logic [1:0]       CMD_KEYPAD   = 2'h0;
	localparam logic [1:0]       CMD_TERMINAL = 2'h1;
	localparam logic [1:0]       CMD_SERIAL   = 2'h2;
	localparam logic             ACT_REVERSE  = 1'b1;
	localparam logic             AUTOCOPY_ON  = 1'b0;
	localparam logic             BACKUP_ON    = 1'b1;

	// feedback filter: time constant in 0.01 s units
	localparam logic [FILT_W-1:0] FILT_MIN  = 10'h001;
	localparam logic [FILT_W-1:0] FILT_MAX  = 10'h3e8;
	localparam logic [FILT_W-1:0] FILT_DEF  = 10'h00a;
	localparam int                FILT_UNIT_US = 10_000;
	localparam int                FILT_TICKS = FILT_UNIT_US / SAMPLE_TIME_US;
	localparam int                FILT_FRAC  = 16;

	// regulator scaling: gains in 0.001, integral ramp time 16 s
	localparam int INT_RAMP_S = 16;
	localparam int GAIN_ONE   = 1000;
	localparam int PCT_ONE    = 10_000;
	localparam int INT_FRAC   = 24;
	localparam logic signed [79:0] PD_DIV  = 80'(GAIN_ONE) * 80'(PCT_ONE);
	localparam logic signed [79:0] INT_DIV = 80'(INT_RAMP_S) * 80'(SAMPLES_PER_S) * PD_DIV;
	localparam logic [29:0]        SCALE_DIV = 30'h0000_2710;

	// regulator operating mode
	typedef enum logic [1:0] {
		MODE_MANUAL = 2'b01,
		MODE_AUTO   = 2'b10
	} dpr_mode_e;

	// true for reference sources that conflict with the regulator
	function automatic logic dpr_bad_ref(input logic [SEL_W-1:0] s);
		return (s == REF_BAD_ONE) || ((s >= REF_BAD_LO) && (s <= REF_BAD_HI));
	endfunction

endpackage

// file: verilog/dpr_pid_if.sv
// signals between the regulator control logic and the arithmetic core
// assumes one clock domain; the control side drives all but the output
`timescale 1ns/10ps
`default_nettype none
interface dpr_pid_if;
	import dpr_pkg::*;
	logic                     tick;   // one-cycle sample strobe
	logic                     run;    // automatic mode active
	logic signed [PCT_W:0]    err;    // signed control error
	logic [GAIN_W-1:0]        kp;     // gains, 0.001 units
	logic [GAIN_W-1:0]        ki;
	logic [GAIN_W-1:0]        kd;
	logic [SPD_W-1:0]         lo_spd; // speed limits
	logic [SPD_W-1:0]         hi_spd;
	logic [SPD_W-1:0]         out;    // limited speed demand

	modport ctrl (output tick, run, err, kp, ki, kd, lo_spd, hi_spd, input out);
	modport core (input tick, run, err, kp, ki, kd, lo_spd, hi_spd, output out);
endinterface
`default_nettype wire

// file: verilog/dpr_pv_filter.sv
// first-order low-pass on the feedback, one update per sample strobe
// assumes strobes are farther apart than the serial divide takes
`timescale 1ns/10ps
`default_nettype none
module dpr_pv_filter
	import dpr_pkg::*;
(
	// clock and reset
	input  wire logic              mclk,
	input  wire logic              arst_n,
	// strobe and time constant
	input  wire logic              tick,
	input  wire logic [FILT_W-1:0] tau,
	// samples
	input  wire logic [PCT_W-1:0]  x,
	output logic      [PCT_W-1:0]  y
);
	localparam int ACC_W = PCT_W + FILT_FRAC;
	localparam int NUM_W = ACC_W + 1;

	logic [ACC_W-1:0]       acc;    // filtered value with fraction
	logic [NUM_W-1:0]       num;    // dividend shifting out
	logic [NUM_W-1:0]       quo;    // quotient shifting in
	logic [DEN_W-1:0]       den;    // time constant in samples
	logic [DEN_W:0]         rem;
	logic [DEN_W:0]         rem_sh;
	logic [5:0]             cnt;
	logic                   neg;    // step direction
	logic                   busy;
	logic                   done;
	logic signed [NUM_W:0]  diff;
	logic [FILT_W-1:0]      tau_c;

	// clamp time constant, form step and next remainder
	always_comb begin
		tau_c = tau;
		if (tau < FILT_MIN) tau_c = FILT_MIN;
		if (tau > FILT_MAX) tau_c = FILT_MAX;
		diff   = signed'({2'b00, x, FILT_FRAC'(0)}) - signed'({2'b00, acc});
		rem_sh = {rem[DEN_W-1:0], num[NUM_W-1]};
	end

	// serial divide of step by time constant; avoids a wide array divider
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			busy <= 1'b0;
			done <= 1'b0;
			cnt  <= 6'h00;
			num  <= '0;
			quo  <= '0;
			rem  <= '0;
			den  <= '0;
			neg  <= 1'b0;
		end else if (busy) begin
			num <= {num[NUM_W-2:0], 1'b0};
			if (rem_sh >= {1'b0, den}) begin
				rem <= rem_sh - {1'b0, den};
				quo <= {quo[NUM_W-2:0], 1'b1};
			end else begin
				rem <= rem_sh;
				quo <= {quo[NUM_W-2:0], 1'b0};
			end
			cnt  <= cnt - 6'h01;
			busy <= (cnt != 6'h01);
			done <= (cnt == 6'h01);
		end else begin
			done <= 1'b0;
			if (tick) begin
				busy <= 1'b1;
				cnt  <= 6'(NUM_W);
				neg  <= diff[NUM_W];
				num  <= diff[NUM_W] ? NUM_W'(-diff) : NUM_W'(diff);
				quo  <= '0;
				rem  <= '0;
				den  <= DEN_W'(tau_c * FILT_TICKS);
			end
		end
	end

	// move output one step toward the input
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			acc <= '0;
		end else if (done) begin
			acc <= neg ? acc - quo[ACC_W-1:0] : acc + quo[ACC_W-1:0];
		end
	end

	assign y = acc[ACC_W-1:FILT_FRAC];
endmodule
`default_nettype wire

// file: verilog/dpr_pid_core.sv
// proportional, integral and derivative arithmetic, one step per strobe
// assumes the control side holds err and settings steady around the strobe
`timescale 1ns/10ps
`default_nettype none
module dpr_pid_core
	import dpr_pkg::*;
(
	// clock and reset
	input  wire logic mclk,
	input  wire logic arst_n,
	// regulator link
	dpr_pid_if.core   pi
);
	logic signed [79:0]  integ;   // integrator, speed with fraction
	logic signed [PCT_W:0] e_prev;
	logic signed [79:0]  hi_s, lo_s, hi_i, lo_i;
	logic signed [79:0]  e_s, inc, pt, dt, i_n, sum;

	// one regulator step, limited to the speed window
	always_comb begin
		hi_s = 80'(signed'({1'b0, pi.hi_spd}));
		lo_s = 80'(signed'({1'b0, pi.lo_spd}));
		hi_i = hi_s <<< INT_FRAC;
		lo_i = lo_s <<< INT_FRAC;
		e_s  = 80'(pi.err);
		// ramp to max in 16/(ki*sp) s with no feedback and no kp
		inc = ((hi_s * 80'(signed'({1'b0, pi.ki})) * e_s) <<< INT_FRAC) / INT_DIV;
		pt  = (hi_s * 80'(signed'({1'b0, pi.kp})) * e_s) / PD_DIV;
		dt  = (hi_s * 80'(signed'({1'b0, pi.kd})) * (e_s - 80'(e_prev))) / PD_DIV;
		i_n = integ + inc;
		if (i_n > hi_i) i_n = hi_i;
		if (i_n < lo_i) i_n = lo_i;
		sum = (i_n >>> INT_FRAC) + pt + dt;
		if (sum > hi_s) sum = hi_s;
		if (sum < lo_s) sum = lo_s;
	end

	// state moves only on the sample strobe
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			integ  <= '0;
			e_prev <= '0;
			pi.out <= '0;
		end else if (pi.tick) begin
			e_prev <= pi.err;
			if (pi.run) begin
				integ  <= i_n;
				pi.out <= SPD_W'(sum);
			end else begin
				// parked at the floor so automatic starts from minimum speed
				integ  <= lo_i;
				pi.out <= pi.lo_spd;
			end
		end
	end
endmodule
`default_nettype wire

// file: verilog/dpr_regulator.sv
// closed-loop process regulator for the inverter speed reference
// assumes all inputs are synchronous to mclk and key inputs are pulses
//
// Functional notes
// - PID on: third input picks manual/automatic.
// - Other input function forces manual mode while it is set.
// - Reference source 1,4-8 raises configuration fault.
// - PID on: no jog, no direction; selected run.
// - Manual mode uses open-loop frequency reference.
// - Manual-to-auto copies process variable into setpoint.
// - Analog output: 6 process variable, 9 setpoint.
// - Direct or reverse action flips error sign.
// - Feedback always from analog input one.
// - Display selection 6 shows scaled process variable.
// - Integral ramps to max in 16/(Ki*SP).
// - Source 0: keypad setpoint, keypad frequency manual.
// - Backup keeps keypad setpoint over disable, power-off.
// - Feedback filter constant 0.01-10.00 s, default 0.10.
// - Speed demand limited to min/max speed.
// - Direct action: error is active setpoint minus process variable.
// - Displayed value is percent times scale factor.
`timescale 1ns/10ps
`default_nettype none
module dpr_regulator
	import dpr_pkg::*;
#(
	parameter int SAMPLE_CYC = SAMPLE_CYCLES // control period, cycles
)(
	// clock and reset
	input  wire logic              mclk,
	input  wire logic              arst_n,
	// function and source settings
	input  wire logic [1:0]        special_function_select,
	input  wire logic [4:0]        mode_input_function,
	input  wire logic              remote_active,
	input  wire logic [SEL_W-1:0]  local_reference_source,
	input  wire logic [SEL_W-1:0]  remote_reference_source,
	input  wire logic [1:0]        local_command_source,
	input  wire logic [1:0]        remote_command_source,
	input  wire logic              action_direction,
	input  wire logic              setpoint_autocopy_select,
	input  wire logic              reference_backup_enable,
	input  wire logic [SEL_W-1:0]  analog_out_function,
	input  wire logic [SEL_W-1:0]  display_default_select,
	// tuning and limits
	input  wire logic [GAIN_W-1:0] proportional_gain,
	input  wire logic [GAIN_W-1:0] integral_gain,
	input  wire logic [GAIN_W-1:0] derivative_gain,
	input  wire logic [SPD_W-1:0]  min_speed_limit,
	input  wire logic [SPD_W-1:0]  max_speed_limit,
	input  wire logic [FILT_W-1:0] feedback_filter_time,
	input  wire logic [GAIN_W-1:0] process_scale_factor,
	// references and stored setpoint
	input  wire logic [SPD_W-1:0]  keypad_freq_reference,
	input  wire logic [SPD_W-1:0]  open_loop_reference,
	input  wire logic [PCT_W-1:0]  backup_setpoint_value,
	// process and operator inputs
	input  wire logic              mode_select_input,
	input  wire logic [PCT_W-1:0]  feedback_analog_input,
	input  wire logic [PCT_W-1:0]  setpoint_analog_input,
	input  wire logic              key_up,
	input  wire logic              key_down,
	input  wire logic              run_cmd_keypad,
	input  wire logic              run_cmd_terminal,
	input  wire logic              run_cmd_serial,
	input  wire logic              jog_cmd,
	input  wire logic              direction_command,
	input  wire logic [PCT_W-1:0]  analog_out_other,
	input  wire logic [PCT_W-1:0]  display_other,
	// drive outputs
	output logic      [SPD_W-1:0]  speed_reference,
	output logic                   run_enable,
	output logic                   jog_enable,
	output logic                   reverse_dir,
	// status outputs
	output logic                   config_fault_code,
	output logic                   auto_mode,
	output logic      [PCT_W-1:0]  keypad_setpoint,
	output logic      [PCT_W-1:0]  process_variable_value,
	output logic      [PCT_W-1:0]  analog_out,
	output logic      [PCT_W-1:0]  display_value
);

	dpr_pid_if pi ();                     // link to arithmetic core

	dpr_mode_e         mode;              // manual or automatic
	dpr_mode_e         next_mode;
	logic [CNT_W-1:0]  tick_cnt;          // sample period counter
	logic              restore_pend;      // backup load after reset
	logic              pid_on;            // regulator function chosen
	logic              mode_in_ok;        // input still set to man/auto
	logic              next_fault;
	logic              next_run;
	logic              run_cmd_sel;       // run from chosen source
	logic [1:0]        cmd_src;
	logic [SEL_W-1:0]  ref_src;           // active reference source
	logic [PCT_W-1:0]  pv_filt;           // filtered feedback
	logic [PCT_W-1:0]  setpoint;          // active setpoint
	logic [SPD_W-1:0]  manual_ref;
	logic [29:0]       pv_scaled;

	// feedback path is fixed to analog input one
	dpr_pv_filter u_filter (
		.mclk   (mclk),
		.arst_n (arst_n),
		.tick   (pi.tick),
		.tau    (feedback_filter_time),
		.x      (feedback_analog_input),
		.y      (pv_filt)
	);

	// regulator arithmetic
	dpr_pid_core u_core (
		.mclk   (mclk),
		.arst_n (arst_n),
		.pi     (pi.ctrl)
	);

	// settings pass straight to the core
	assign pi.kp     = proportional_gain;
	assign pi.ki     = integral_gain;
	assign pi.kd     = derivative_gain;
	assign pi.lo_spd = min_speed_limit;
	assign pi.hi_spd = max_speed_limit;
	assign pi.run    = (mode == MODE_AUTO);

	// decode of settings and command selection
	always_comb begin
		pid_on     = (special_function_select == SFS_PID);
		mode_in_ok = (mode_input_function == MIF_MAN_AUTO);
		ref_src    = remote_active ? remote_reference_source : local_reference_source;
		cmd_src    = remote_active ? remote_command_source : local_command_source;
		next_fault = pid_on && (dpr_bad_ref(local_reference_source) ||
			dpr_bad_ref(remote_reference_source));
		// run comes only from the source picked for local or remote
		case (cmd_src)
			CMD_KEYPAD:   run_cmd_sel = run_cmd_keypad;
			CMD_TERMINAL: run_cmd_sel = run_cmd_terminal;
			CMD_SERIAL:   run_cmd_sel = run_cmd_serial;
			default:      run_cmd_sel = 1'b0;
		endcase
		// a faulted drive is held disabled
		next_run = run_cmd_sel && !config_fault_code;
		// automatic setpoint: keypad value or second analog input
		setpoint = (ref_src == REF_AI2) ? setpoint_analog_input : keypad_setpoint;
		// manual reference: keypad frequency or open-loop reference
		manual_ref = (ref_src == REF_KEYPAD) ? keypad_freq_reference
			: open_loop_reference;
		pv_scaled = (30'(process_variable_value) * 30'(process_scale_factor))
			/ SCALE_DIV;
	end

	// next mode from the selector input
	always_comb begin
		next_mode = MODE_MANUAL;
		// a changed input function leaves only manual mode
		if (pid_on && mode_in_ok && mode_select_input && !next_fault) begin
			next_mode = MODE_AUTO;
		end
	end

	// sample strobe for filter and regulator
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			tick_cnt <= '0;
			pi.tick  <= 1'b0;
		end else if (tick_cnt == CNT_W'(SAMPLE_CYC - 1)) begin
			tick_cnt <= '0;
			pi.tick  <= 1'b1;
		end else begin
			tick_cnt <= tick_cnt + 1'b1;
			pi.tick  <= 1'b0;
		end
	end

	// control error, sign set by action direction
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			pi.err <= '0;
		end else if (action_direction == ACT_REVERSE) begin
			// reverse: raising speed lowers the process variable
			pi.err <= signed'({1'b0, pv_filt}) - signed'({1'b0, setpoint});
		end else begin
			// direct: speed rises while the variable sits below setpoint
			pi.err <= signed'({1'b0, setpoint}) - signed'({1'b0, pv_filt});
		end
	end

	// operating mode state
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			mode <= MODE_MANUAL;
		end else begin
			unique case (mode)
				MODE_MANUAL: begin
					if (next_mode == MODE_AUTO) mode <= MODE_AUTO;
				end
				MODE_AUTO: begin
					if (next_mode == MODE_MANUAL) mode <= MODE_MANUAL;
				end
			endcase
		end
	end

	// configuration fault, present while the settings conflict
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			config_fault_code <= 1'b0;
		end else begin
			config_fault_code <= next_fault;
		end
	end

	// drive commands; jog and direction are locked out under the regulator
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			run_enable  <= 1'b0;
			jog_enable  <= 1'b0;
			reverse_dir <= 1'b0;
		end else begin
			run_enable  <= next_run;
			jog_enable  <= jog_cmd && !pid_on;
			reverse_dir <= direction_command && !pid_on;
		end
	end

	// keypad setpoint: restore, bumpless copy, disable clear, keys
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			keypad_setpoint <= '0;
			restore_pend    <= 1'b1;
		end else begin
			restore_pend <= 1'b0;
			if (restore_pend) begin
				// stored value comes back only with backup on
				keypad_setpoint <= (reference_backup_enable == BACKUP_ON)
					? backup_setpoint_value : '0;
			end else if (mode == MODE_MANUAL && next_mode == MODE_AUTO &&
				setpoint_autocopy_select == AUTOCOPY_ON) begin
				// value held just before the switch, so on the keypad setpoint the error starts near zero
				keypad_setpoint <= process_variable_value;
			end else if (run_enable && !next_run &&
				reference_backup_enable != BACKUP_ON) begin
				keypad_setpoint <= '0;
			end else if (pid_on && key_up && !key_down) begin
				if (keypad_setpoint < PCT_FULL) keypad_setpoint <= keypad_setpoint + PCT_STEP;
			end else if (pid_on && key_down && !key_up) begin
				if (keypad_setpoint != '0) keypad_setpoint <= keypad_setpoint - PCT_STEP;
			end
		end
	end

	// speed reference: regulator in automatic, open loop otherwise
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			speed_reference <= '0;
			auto_mode       <= 1'b0;
		end else begin
			auto_mode <= (mode == MODE_AUTO);
			if (pid_on && mode == MODE_AUTO) begin
				speed_reference <= pi.out;
			end else begin
				speed_reference <= manual_ref;
			end
		end
	end

	// process variable, analog output and display
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			process_variable_value <= '0;
			analog_out             <= '0;
			display_value          <= '0;
		end else begin
			process_variable_value <= pv_filt;
			// other functions of the output come from the drive
			if (analog_out_function == AO_PV) begin
				analog_out <= process_variable_value;
			end else if (analog_out_function == AO_SP) begin
				analog_out <= setpoint;
			end else begin
				analog_out <= analog_out_other;
			end
			if (display_default_select == DISP_PV) begin
				display_value <= PCT_W'(pv_scaled);
			end else begin
				display_value <= display_other;
			end
		end
	end

endmodule
`default_nettype wire

// file: verification/dpr_process_model.sv
// transducer model standing on the feedback input of the regulator
// assumes input gain 1.00 and offset 0, so the level is percent of full scale
`timescale 1ns/10ps
`default_nettype none
module dpr_process_model
	import dpr_pkg::*;
(
	// clock
	input  wire logic             mclk,
	// requested process level and sensor output
	input  wire logic [PCT_W-1:0] level,
	output logic      [PCT_W-1:0] fb
);
	// starts at zero so the input is never unknown
	initial fb = 16'h0000;
	// sensor lags one cycle and saturates at full scale
	always @(posedge mclk) begin
		fb <= (level > PCT_FULL) ? PCT_FULL : level;
	end
endmodule
`default_nettype wire

// file: verification/dpr_regulator_asserts.sv
// port-level checks on the regulator, bound into every instance
// assumes one clock, mclk, with asynchronous reset arst_n
`timescale 1ns/10ps
`default_nettype none
module dpr_regulator_asserts
	import dpr_pkg::*;
(
	// clock and reset
	input wire logic             mclk,
	input wire logic             arst_n,
	// settings
	input wire logic [1:0]       special_function_select,
	input wire logic [4:0]       mode_input_function,
	input wire logic             remote_active,
	input wire logic [SEL_W-1:0] local_reference_source,
	input wire logic [SEL_W-1:0] remote_reference_source,
	input wire logic             setpoint_autocopy_select,
	input wire logic             reference_backup_enable,
	input wire logic [SEL_W-1:0] analog_out_function,
	input wire logic [SEL_W-1:0] display_default_select,
	input wire logic [SPD_W-1:0] min_speed_limit,
	input wire logic [SPD_W-1:0] max_speed_limit,
	input wire logic [GAIN_W-1:0] process_scale_factor,
	input wire logic [SPD_W-1:0] keypad_freq_reference,
	input wire logic [SPD_W-1:0] open_loop_reference,
	// operator inputs
	input wire logic             mode_select_input,
	input wire logic             key_up,
	input wire logic             key_down,
	// outputs watched
	input wire logic [SPD_W-1:0] speed_reference,
	input wire logic             jog_enable,
	input wire logic             reverse_dir,
	input wire logic             config_fault_code,
	input wire logic             auto_mode,
	input wire logic [PCT_W-1:0] keypad_setpoint,
	input wire logic [PCT_W-1:0] process_variable_value,
	input wire logic [PCT_W-1:0] analog_out,
	input wire logic [PCT_W-1:0] display_value
);
	// sources that clash with the regulator
	function automatic logic bad_src(input logic [SEL_W-1:0] s);
		return (s == 4'h1) || ((s >= 4'h4) && (s <= 4'h8));
	endfunction
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!arst_n);
	fault_src_a: assert property (1'b1 |=> config_fault_code == $past(
		(special_function_select == SFS_PID) &&
		(bad_src(local_reference_source) || bad_src(remote_reference_source))))
		else $error("fault flag does not follow the sources");
	jog_block_a: assert property (special_function_select == SFS_PID |=>
		!jog_enable && !reverse_dir) else $error("jog or direction passed");
	auto_entry_a: assert property ($rose(auto_mode) |-> $past(mode_select_input, 2) &&
		$past(mode_input_function, 2) == MIF_MAN_AUTO) else $error("auto without cause");
	manual_hold_a: assert property (mode_input_function != MIF_MAN_AUTO |-> ##2
		!auto_mode) else $error("auto with wrong input function");
	manual_ref_a: assert property (!auto_mode ##1 !auto_mode |-> speed_reference ==
		$past(((remote_active ? remote_reference_source : local_reference_source)
		== REF_KEYPAD) ? keypad_freq_reference : open_loop_reference))
		else $error("manual speed reference wrong");
	speed_range_a: assert property (auto_mode |-> (speed_reference >= min_speed_limit) &&
		(speed_reference <= max_speed_limit)) else $error("speed outside limits");
	copy_pv_a: assert property ($rose(auto_mode) && setpoint_autocopy_select == AUTOCOPY_ON
		|-> keypad_setpoint == $past(process_variable_value, 2) ||
		keypad_setpoint == $past(process_variable_value, 1)) else $error("setpoint not copied");
	ao_pv_a: assert property (analog_out_function == AO_PV |=>
		analog_out == $past(process_variable_value)) else $error("analog output not pv");
	disp_pv_a: assert property (display_default_select == DISP_PV |=> display_value ==
		16'((32'($past(process_variable_value)) * 32'($past(process_scale_factor)))
		/ 32'h0000_2710)) else $error("display not scaled pv");
	key_step_a: assert property (special_function_select == SFS_PID && key_up && !key_down
		&& keypad_setpoint < PCT_FULL && reference_backup_enable && !mode_select_input
		|=> keypad_setpoint == $past(keypad_setpoint) + 16'h0001) else $error("key step lost");
endmodule
bind dpr_regulator dpr_regulator_asserts chk (.*);
`default_nettype wire

// file: verification/dpr_regulator_tb_top.sv
// self-checking bench for the process regulator
// assumes the transducer model on the feedback input and a 10 MHz mclk
`timescale 1ns/10ps
`default_nettype none
module dpr_regulator_tb_top;
	import dpr_pkg::*;
	localparam int SC = 50; // short period, brief run
	// clock, reset and settings
	logic mclk = 1'b0, arst_n = 1'b0;
	logic [1:0] special_function_select = SFS_PID, local_command_source = CMD_TERMINAL;
	logic [1:0] remote_command_source = CMD_SERIAL;
	logic [4:0] mode_input_function = MIF_MAN_AUTO;
	logic remote_active = 1'b0, action_direction = 1'b0;
	logic setpoint_autocopy_select = AUTOCOPY_ON, reference_backup_enable = BACKUP_ON;
	logic [3:0] local_reference_source = REF_KEYPAD, remote_reference_source = REF_AI2;
	logic [3:0] analog_out_function = AO_PV, display_default_select = DISP_PV;
	logic [13:0] proportional_gain = 14'h1f3f, integral_gain = 14'h0000;
	logic [13:0] derivative_gain = 14'h0000, process_scale_factor = 14'h00c8;
	logic [15:0] min_speed_limit = 16'h0100, max_speed_limit = 16'h1000;
	logic [15:0] keypad_freq_reference = 16'h0222, open_loop_reference = 16'h0333;
	logic [15:0] backup_setpoint_value = 16'h0123, setpoint_analog_input = 16'h2710;
	logic [15:0] analog_out_other = 16'h0abc, display_other = 16'h0def, level = 16'h0fa0;
	logic [9:0] feedback_filter_time = FILT_MIN; // fastest filter settles soonest
	// operator inputs; jog and direction held on
	logic mode_select_input = 1'b0, key_up = 1'b0, key_down = 1'b0;
	logic run_cmd_keypad = 1'b0, run_cmd_terminal = 1'b0, run_cmd_serial = 1'b0;
	logic jog_cmd = 1'b1, direction_command = 1'b1;
	// design outputs
	wire logic [15:0] feedback_analog_input, speed_reference, keypad_setpoint;
	wire logic [15:0] process_variable_value, analog_out, display_value;
	wire logic run_enable, jog_enable, reverse_dir, config_fault_code, auto_mode;
	int fail_count = 0;
	int tests_run = 0;
	always #50 mclk = ~mclk;
	dpr_process_model pm (.mclk, .level, .fb(feedback_analog_input));
	dpr_regulator #(.SAMPLE_CYC(SC)) dut (.*);
	// inputs always move 1 ns after the edge
	task automatic tick(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		tests_run++;
		if (got !== exp) begin
			fail_count++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// filtered values may sit a few counts off; an unknown still mismatches
	task automatic chk_near(input logic [15:0] got, input logic [15:0] exp);
		chk(((got + 16'h0004 >= exp) && (got <= exp + 16'h0004)) ? exp : got, exp);
	endtask
	// bounded wait for a speed demand; a timeout is a mismatch
	task automatic wait_spd(input logic [15:0] exp);
		repeat (8 * SC) if (speed_reference !== exp) tick(1);
		chk(speed_reference, exp);
		if (speed_reference !== exp) tally_and_finish();
	endtask
	task automatic done(input string s);
		$display("test %s done", s);
	endtask
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	initial begin
		tick(15);
		chk(keypad_setpoint, 16'h0000);
		tick(1);
		arst_n = 1'b1;
		tick(2);
		chk(keypad_setpoint, 16'h0123);
		chk({15'h0000, jog_enable | reverse_dir}, 16'h0000);
		done("reset");
		// local source codes 0 to 9, then one bad remote code
		for (int i = 0; i < 10; i++) begin
			local_reference_source = 4'(i);
			tick(2);
			chk({15'h0000, config_fault_code}, 16'((i == 1) || (i >= 4 && i <= 8)));
		end
		local_reference_source = REF_KEYPAD;
		remote_reference_source = 4'h7;
		tick(2);
		chk({15'h0000, config_fault_code}, 16'h0001);
		remote_reference_source = REF_AI2;
		done("fault");
		// run taken only from the selected command source
		for (int c = 0; c < 4; c++) begin
			for (int r = 0; r < 3; r++) begin
				local_command_source = 2'(c);
				{run_cmd_serial, run_cmd_terminal, run_cmd_keypad} = 3'(1 << r);
				tick(2);
				chk({15'h0000, run_enable}, 16'(c == r));
			end
		end
		done("command");
		chk(speed_reference, 16'h0222);
		remote_active = 1'b1;
		tick(2);
		chk(speed_reference, 16'h0333);
		remote_active = 1'b0;
		key_up = 1'b1;
		tick(1);
		key_up = 1'b0;
		tick(1);
		chk(keypad_setpoint, 16'h0124);
		key_down = 1'b1;
		tick(1);
		key_down = 1'b0;
		tick(1);
		chk(keypad_setpoint, 16'h0123);
		done("manual");
		tick(100 * SC);
		chk_near(process_variable_value, 16'h0fa0);
		chk_near(display_value, 16'h0050);
		chk_near(analog_out, 16'h0fa0);
		analog_out_function = AO_SP;
		tick(2);
		chk(analog_out, 16'h0123);
		analog_out_function = 4'h0;
		display_default_select = 4'h0;
		tick(2);
		chk(analog_out, 16'h0abc);
		chk(display_value, 16'h0def);
		done("monitor");
		mode_input_function = 5'h0e;
		mode_select_input = 1'b1;
		tick(3);
		chk({15'h0000, auto_mode}, 16'h0000);
		mode_input_function = MIF_MAN_AUTO;
		tick(3);
		chk({15'h0000, auto_mode}, 16'h0001);
		chk_near(keypad_setpoint, 16'h0fa0);
		local_reference_source = REF_AI2;
		wait_spd(16'h1000);
		action_direction = ACT_REVERSE;
		wait_spd(16'h0100);
		mode_select_input = 1'b0;
		tick(3);
		chk(speed_reference, 16'h0333);
		done("auto");
		arst_n = 1'b0;
		reference_backup_enable = 1'b0;
		tick(2);
		chk({15'h0000, auto_mode}, 16'h0000);
		arst_n = 1'b1;
		tick(2);
		chk(keypad_setpoint, 16'h0000);
		done("second reset");
		tally_and_finish();
	end
endmodule
`default_nettype wire
